//--- src/phystat_regs.sv
// phy basic status and identifier register bank
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module phystat_regs
  import phystat_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [23:0] ORG_ID = 24'h00A5C3,
  parameter logic [5:0] MODEL_NUM = 6'h2A,
  parameter logic [3:0] REVISION_NUM = 4'h3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic negotiationDone,
  input wire logic remoteFault,
  input wire logic linkUp,
  input wire logic babble,
  output logic shortPreambleAccept,
  output logic irq
);

  // ***************************************
  // input synchronisers
  // ***************************************
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic negDoneS;
  logic faultS;
  logic linkS;
  logic babbleS;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
    end else begin
      syncA_q <= {babble, linkUp, remoteFault, negotiationDone};
      syncB_q <= syncA_q;
    end
  end

  assign negDoneS = syncB_q[0];
  assign faultS = syncB_q[1];
  assign linkS = syncB_q[2];
  assign babbleS = syncB_q[3];

  // ***************************************
  // latched status fields
  // ***************************************
  logic statusRead;
  logic faultLatched_q;
  logic babbleLatched_q;
  logic linkLatchedLow_q;
  logic linkPrev_q;
  logic negPrev_q;

  assign statusRead = regRead && (regAddr == OFS_BASIC_STATUS);
  assign shortPreambleAccept = 1'b1; // RL3

  // event during the read cycle wins, so it is never lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      faultLatched_q <= 1'b0;
    end else if (faultS) begin
      faultLatched_q <= 1'b1; // RL5
    end else if (statusRead) begin
      faultLatched_q <= 1'b0; // RL5
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      babbleLatched_q <= 1'b0;
    end else if (babbleS) begin
      babbleLatched_q <= 1'b1; // RL8
    end else if (statusRead) begin
      babbleLatched_q <= 1'b0; // RL8
    end
  end

  // latch low: loss holds zero; a read reloads the present level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkLatchedLow_q <= 1'b0;
    end else if (!linkS) begin
      linkLatchedLow_q <= 1'b0; // RL7
    end else if (statusRead) begin
      linkLatchedLow_q <= 1'b1; // RL7
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      linkPrev_q <= 1'b0;
      negPrev_q <= 1'b0;
    end else begin
      linkPrev_q <= linkS;
      negPrev_q <= negDoneS;
    end
  end

  // ***************************************
  // register images
  // ***************************************
  logic [15:0] basicStatus;
  logic [15:0] idHigh;
  logic [15:0] idLow;

  always_comb begin
    basicStatus = 16'h0000;
    basicStatus[BIT_FAST_FULL] = 1'b1; // RL1
    basicStatus[BIT_FAST_HALF] = 1'b1; // RL1
    basicStatus[BIT_SLOW_FULL] = 1'b1; // RL1
    basicStatus[BIT_SLOW_HALF] = 1'b1; // RL1
    basicStatus[BIT_GIGABIT_STATUS] = 1'b1; // RL2
    basicStatus[BIT_SHORT_PREAMBLE] = shortPreambleAccept; // RL3
    basicStatus[BIT_NEG_DONE] = negDoneS; // RL4
    basicStatus[BIT_REMOTE_FAULT] = faultLatched_q; // RL5
    basicStatus[BIT_NEG_ABLE] = 1'b1; // RL6
    basicStatus[BIT_LINK_UP] = linkLatchedLow_q; // RL7
    basicStatus[BIT_BABBLE] = babbleLatched_q; // RL8
    basicStatus[BIT_EXT_REGS] = 1'b1; // RL9
  end

  // org id bit 1 is the msb, i.e. ORG_ID[23]; bits 3..18 are [21:6]
  assign idHigh = ORG_ID[21:6]; // RL10 RL11
  assign idLow = {ORG_ID[5:0], MODEL_NUM, REVISION_NUM}; // RL10 RL12 RL13 RL14

  // ***************************************
  // interrupts
  // ***************************************
  logic [3:0] irqStatus_q;
  logic [3:0] irqMask_q;
  logic [3:0] irqEvent;
  logic [3:0] irqClear;

  assign irqEvent = {negDoneS & ~negPrev_q, linkPrev_q & ~linkS, babbleS, faultS};
  assign irqClear = (regWrite && regAddr == OFS_IRQ_STATUS) ? regWdata[3:0] : 4'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStatus_q <= IRQ_RESET;
    end else begin
      irqStatus_q <= (irqStatus_q & ~irqClear) | irqEvent;
    end
  end

  // status and identifier writes fall through: no storage to change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMask_q <= IRQ_RESET;
    end else if (regWrite && regAddr == OFS_IRQ_MASK) begin
      irqMask_q <= regWdata[3:0]; // RL15
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  // ***************************************
  // read port
  // ***************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= RDATA_RESET;
    end else if (regRead) begin
      case (regAddr)
        OFS_BASIC_STATUS: regRdata <= basicStatus;
        OFS_IDENTIFIER_HIGH: regRdata <= idHigh;
        OFS_IDENTIFIER_LOW: regRdata <= idLow;
        OFS_IRQ_STATUS: regRdata <= {12'h000, irqStatus_q};
        OFS_IRQ_MASK: regRdata <= {12'h000, irqMask_q};
        default: regRdata <= RDATA_RESET;
      endcase
    end else begin
      regRdata <= RDATA_RESET;
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  property p_caps;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_BASIC_STATUS |=> regRdata[14:11] == 4'hF && regRdata[8] && regRdata[6];
  endproperty
  a_caps: assert property (p_caps) else $error("capability bits not one"); // RL1

  property p_ext;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_BASIC_STATUS |=> regRdata[3] && regRdata[0] && !regRdata[15];
  endproperty
  a_ext: assert property (p_ext) else $error("ability bits wrong"); // RL9

  property p_negdone;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_BASIC_STATUS |=> regRdata[5] == $past(negDoneS);
  endproperty
  a_negdone: assert property (p_negdone) else $error("negotiation done mismatch"); // RL4

  property p_faultclr;
    @(posedge core_clk) disable iff (rst)
      statusRead && !faultS ##1 !faultS |=> !regRdata[4] || !$past(statusRead);
  endproperty
  a_faultclr: assert property (p_faultclr) else $error("fault not cleared"); // RL5

  property p_fault;
    @(posedge core_clk) disable iff (rst) faultS |=> faultLatched_q;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not latched"); // RL5

  property p_babble;
    @(posedge core_clk) disable iff (rst) statusRead && !babbleS |=> !babbleLatched_q;
  endproperty
  a_babble: assert property (p_babble) else $error("babble not cleared"); // RL8

  property p_linklow;
    @(posedge core_clk) disable iff (rst) !linkS ##1 (linkS && !statusRead) [*2] |-> !linkLatchedLow_q;
  endproperty
  a_linklow: assert property (p_linklow) else $error("link latch released early"); // RL7

  property p_id;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_IDENTIFIER_LOW |=> regRdata == {ORG_ID[5:0], MODEL_NUM, REVISION_NUM};
  endproperty
  a_id: assert property (p_id) else $error("identifier low wrong"); // RL12

  property p_idhi;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_IDENTIFIER_HIGH |=> regRdata == ORG_ID[21:6];
  endproperty
  a_idhi: assert property (p_idhi) else $error("identifier high wrong"); // RL11

  property p_shortpre;
    @(posedge core_clk) disable iff (rst)
      shortPreambleAccept;
  endproperty
  a_shortpre: assert property (p_shortpre) else $error("short preamble flag low"); // RL3

  property p_reserved;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_BASIC_STATUS |=> regRdata[10:9] == 2'h0 && !regRdata[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set"); // RL1

  property p_fault_hold;
    @(posedge core_clk) disable iff (rst)
      faultLatched_q && !statusRead |=> faultLatched_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault latch lost"); // RL5

  property p_fault_read;
    @(posedge core_clk) disable iff (rst)
      statusRead && faultLatched_q |=> regRdata[4];
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault not reported"); // RL5

  property p_babble_set;
    @(posedge core_clk) disable iff (rst)
      babbleS |=> babbleLatched_q;
  endproperty
  a_babble_set: assert property (p_babble_set) else $error("babble not latched"); // RL8

  property p_babble_hold;
    @(posedge core_clk) disable iff (rst)
      babbleLatched_q && !statusRead |=> babbleLatched_q;
  endproperty
  a_babble_hold: assert property (p_babble_hold) else $error("babble latch lost"); // RL8

  property p_babble_read;
    @(posedge core_clk) disable iff (rst)
      statusRead && babbleLatched_q |=> regRdata[1];
  endproperty
  a_babble_read: assert property (p_babble_read) else $error("babble not reported"); // RL8

  property p_link_drop;
    @(posedge core_clk) disable iff (rst)
      !linkS |=> !linkLatchedLow_q;
  endproperty
  a_link_drop: assert property (p_link_drop) else $error("link loss not latched"); // RL7

  property p_link_reload;
    @(posedge core_clk) disable iff (rst)
      statusRead && linkS |=> linkLatchedLow_q;
  endproperty
  a_link_reload: assert property (p_link_reload) else $error("link not reloaded on read"); // RL7

  property p_link_read;
    @(posedge core_clk) disable iff (rst)
      statusRead |=> regRdata[2] == $past(linkLatchedLow_q);
  endproperty
  a_link_read: assert property (p_link_read) else $error("link bit not reported"); // RL7

  property p_idlo_model;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_IDENTIFIER_LOW |=> regRdata[9:4] == MODEL_NUM;
  endproperty
  a_idlo_model: assert property (p_idlo_model) else $error("model number wrong"); // RL13

  property p_idlo_rev;
    @(posedge core_clk) disable iff (rst)
      regRead && regAddr == OFS_IDENTIFIER_LOW |=> regRdata[3:0] == REVISION_NUM;
  endproperty
  a_idlo_rev: assert property (p_idlo_rev) else $error("revision number wrong"); // RL14

  property p_status_wr;
    @(posedge core_clk) disable iff (rst)
      regWrite && !regRead && regAddr == OFS_BASIC_STATUS && !faultS |=> faultLatched_q == $past(faultLatched_q);
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write changed a field"); // RL15

  property p_rdata_idle;
    @(posedge core_clk) disable iff (rst)
      !regRead |=> regRdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_irq_set;
    @(posedge core_clk) disable iff (rst)
      faultS |=> irqStatus_q[IRQ_FAULT];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("fault event not flagged");

  property p_irq_clear;
    @(posedge core_clk) disable iff (rst)
      regWrite && regAddr == OFS_IRQ_STATUS && regWdata[3:0] == 4'hF && irqEvent == 4'h0 |=> irqStatus_q == 4'h0;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("event flags not cleared");

  property p_irq_mask;
    @(posedge core_clk) disable iff (rst)
      regWrite && regAddr == OFS_IRQ_MASK |=> irqMask_q == $past(regWdata[3:0]);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("mask write lost");

  property p_irq_off;
    @(posedge core_clk) disable iff (rst)
      irqMask_q == 4'h0 |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");

endmodule : phystat_regs
`default_nettype wire

//--- src/phystat_pkg.sv
// constants and register layout of the phy status and identifier bank
// Notes on behaviour
// (RL1) capability bits 14..11 read one: fast and slow, full and half duplex
// (RL2) bit 8 reads one: gigabit abilities live in extended status register 0x0F; the read port does not decode 0x0F, so a read there returns zero
// (RL3) bit 6 reads one; frames with suppressed preamble are accepted
// (RL4) bit 5 reads zero until negotiation completes, then one
// (RL5) bit 4 sets on remote fault, clears when the register is read
// (RL6) bit 3 reads one: negotiation able
// (RL7) bit 2 latches low on link loss until read; reread for current state
// (RL8) bit 1 sets on jabber, clears when the register is read
// (RL9) bit 0 reads one: extended register set present
// (RL10) both identifier registers form a 32-bit org id, model, revision value
// (RL11) first identifier register holds org id bits 3..18; top two bits dropped
// (RL12) second identifier bits 15..10 hold org id bits 19..24 in order
// (RL13) second identifier bits 9..4 hold six-bit model number, msb at 9
// (RL14) second identifier bits 3..0 hold four-bit revision, msb at 3
// (RL15) writes to status and identifier registers are ignored
package phystat_pkg;
  localparam logic [4:0] OFS_BASIC_STATUS = 5'h01;
  localparam logic [4:0] OFS_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] OFS_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h11;
  localparam logic [4:0] OFS_EXT_STATUS = 5'h0F;
  localparam int BIT_FAST_FULL = 14;
  localparam int BIT_FAST_HALF = 13;
  localparam int BIT_SLOW_FULL = 12;
  localparam int BIT_SLOW_HALF = 11;
  localparam int BIT_GIGABIT_STATUS = 8;
  localparam int BIT_SHORT_PREAMBLE = 6;
  localparam int BIT_NEG_DONE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_NEG_ABLE = 3;
  localparam int BIT_LINK_UP = 2;
  localparam int BIT_BABBLE = 1;
  localparam int BIT_EXT_REGS = 0;
  localparam logic [15:0] BASIC_STATUS_RESET = 16'h7949;
  // irq status bits: remote fault, babble, link loss, negotiation done
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_BABBLE = 1;
  localparam int IRQ_LINK_LOSS = 2;
  localparam int IRQ_NEG_DONE = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
endpackage : phystat_pkg

//--- sim/phystat_host.sv
// management host model on the register port
`timescale 1ns/10ps
`default_nettype none
module phystat_host (
  input wire logic core_clk,
  output logic [4:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [15:0] regRdata
);
  initial begin
    regAddr = 5'h00;
    regWdata = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // idle bus shows inverted values, not a stale match
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask : rd
endmodule : phystat_host
`default_nettype wire

//--- sim/phystat_regs_test.sv
// self-checking bench of the status and identifier bank
`timescale 1ns/10ps
`default_nettype none
module phystat_regs_test;
  import phystat_pkg::*;
  // arbitrary identity values
  localparam logic [23:0] ORG = 24'h00A5C3;
  localparam logic [5:0] MODEL = 6'h2A;
  localparam logic [3:0] REV = 4'h3;
  logic core_clk, rst, negotiationDone, remoteFault, linkUp, babble;
  logic regWrite, regRead, shortPreambleAccept, irq;
  logic [4:0] regAddr;
  logic [15:0] regWdata, regRdata;
  int badCount, checked;
  phystat_regs #(.ORG_ID(ORG), .MODEL_NUM(MODEL), .REVISION_NUM(REV)) phystat_regs_inst (.core_clk, .rst,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .negotiationDone, .remoteFault, .linkUp, .babble,
    .shortPreambleAccept, .irq);
  phystat_host phystat_host_inst (.core_clk, .regAddr, .regWdata, .regWrite, .regRead, .regRdata);
  // ***********
  // helpers
  // ***********
  function automatic logic [15:0] stat(input logic nd, rf, lk, bb);
    return 16'h7949 | {10'h000, nd, rf, 1'b0, lk, bb, 1'b0};
  endfunction : stat
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    phystat_host_inst.rd(a, d);
    check($sformatf("reg%h", a), exp, d);
  endtask : rc
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic testDone;
    if (badCount == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : testDone
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // watchdog: waits are fixed or at most five cycles, this only guards a stall
  initial begin
    idle(5000);
    badCount++;
    testDone;
  end
  // ***********
  // scenarios
  // ***********
  initial begin
    {rst, negotiationDone, remoteFault, linkUp, babble} = 5'h10;
    badCount = 0;
    checked = 0;
    void'($urandom(13411));
    idle(20);
    rst <= 1'b0;
    rc(OFS_BASIC_STATUS, stat(0, 0, 0, 0));
    rc(OFS_IDENTIFIER_HIGH, ORG[21:6]);
    rc(OFS_IDENTIFIER_LOW, {ORG[5:0], MODEL, REV});
    check("preamble", 16'h0001, {15'h0000, shortPreambleAccept});
    for (int i = 0; i < 9; i++) begin
      phystat_host_inst.wr(5'h01 + 5'(i % 3), 16'($urandom));
    end
    rc(OFS_BASIC_STATUS, stat(0, 0, 0, 0));
    rc(OFS_IDENTIFIER_HIGH, ORG[21:6]);
    rc(OFS_IDENTIFIER_LOW, {ORG[5:0], MODEL, REV});
    for (int k = 0; k < 2; k++) begin
      remoteFault <= (k == 0);
      babble <= (k == 1);
      idle(1 + $urandom_range(4));
      {remoteFault, babble} <= 2'b00;
      idle(4);
      rc(OFS_BASIC_STATUS, stat(0, k == 0, 0, k == 1));
      rc(OFS_BASIC_STATUS, stat(0, 0, 0, 0));
    end
    for (int k = 0; k < 2; k++) begin
      linkUp <= 1'b1;
      idle(4);
      rc(OFS_BASIC_STATUS, stat(0, 0, 0, 0));
      rc(OFS_BASIC_STATUS, stat(0, 0, 1, 0));
      linkUp <= 1'b0;
      idle(3);
    end
    linkUp <= 1'b1;
    negotiationDone <= 1'b1;
    idle(4);
    rc(OFS_BASIC_STATUS, stat(1, 0, 0, 0));
    check("irqMasked", 16'h0000, {15'h0000, irq});
    phystat_host_inst.wr(OFS_IRQ_MASK, 16'h0001);
    rc(OFS_IRQ_MASK, 16'h0001);
    phystat_host_inst.wr(OFS_IRQ_STATUS, 16'h000F);
    rc(OFS_IRQ_STATUS, 16'h0000);
    check("irqIdle", 16'h0000, {15'h0000, irq});
    remoteFault <= 1'b1;
    idle(4);
    check("irqSet", 16'h0001, {15'h0000, irq});
    remoteFault <= 1'b0;
    idle(3);
    rc(OFS_IRQ_STATUS, 16'h0001);
    phystat_host_inst.wr(OFS_IRQ_STATUS, 16'h000F);
    idle(1);
    check("irqClear", 16'h0000, {15'h0000, irq});
    rc(OFS_BASIC_STATUS, stat(1, 1, 1, 0));
    rc(5'h1F, 16'h0000);
    testDone;
  end
endmodule : phystat_regs_test
`default_nettype wire
